// *** rtl/mbx_consts.vh ***
// Constants of the host message mailbox: register indices, fields, resets
`ifndef MBX_CONSTS_VH
`define MBX_CONSTS_VH

// ======================================================================
// Register indices (byte address is four times the index)
`define IDX_RD_PTR 4'h0
`define IDX_WR_PTR 4'h1
`define IDX_DATA 4'h2
`define IDX_HOST_HDR 4'h3
`define IDX_HOST_CTRL_HI 4'h4
`define IDX_HOST_COUNT 4'h5
`define IDX_DEV_HDR 4'h6
`define IDX_DEV_CTRL_HI 4'h7
`define IDX_DEV_COUNT 4'h8
`define IDX_STATUS 4'h9
`define IDX_CONTROL 4'hA
`define IDX_DEV_ACK 4'hB
`define IDX_LAST 4'hB

// ======================================================================
// Field positions
`define STAT_BUSY_BIT 0
`define STAT_PEND_BIT 1
`define CTL_ATTN_EN_BIT 0
`define ACK_BIT 0
`define HDR_PATH_HI 7
`define HDR_PATH_LO 6

// ======================================================================
// Reset values and bus answers
`define RST_BYTE 8'h00
`define RST_ATTN_EN 1'b0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define MBX_AW 8

`endif

// *** rtl/mbx_ram.v ***
// Byte-wide mailbox storage held in flip-flops, one write, one read port
`timescale 1ns/100ps
module mbx_ram #(
  parameter AW = 8
) (
  input wire sys_clk,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [7:0] wr_data,
  input wire [AW-1:0] rd_addr,
  output wire [7:0] rd_data
);
  reg [7:0] mem_q [0:(1<<AW)-1];

  // ====================================================================
  // Storage
  // No reset: contents survive from one message to the next
  always @(posedge sys_clk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  assign rd_data = mem_q[rd_addr];
endmodule

// *** rtl/host_message_mailbox.v ***
// Host message mailbox with AXI4-Lite registers and internal message ports
//
// Notes on behaviour
// - Write pointer advances per data write
// - Mailbox contents persist between messages
// - Header access commits, sets busy
// - Message moved to header-selected datapath
// - Attention asserted when message waits, enabled
// - Disabled attention still sets pending flag
// - Device presents control bytes with count
// - Read pointer advances per data read
// - Ack clear consumes message, frees mailbox
// - Ack alone discards whole message
// - Responses only after host request
// - Unmasked GPIO change sends level report
// - Zero count means no mailbox data
`timescale 1ns/100ps
`include "mbx_consts.vh"
module host_message_mailbox #(
  parameter AW = `MBX_AW,
  parameter GPIO_W = 8,
  parameter [7:0] GPIO_QUERY_HDR = 8'hF0,
  parameter [7:0] GPIO_REPORT_HDR = 8'hF1
) (
  input wire sys_clk,
  input wire rst_n,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  output wire host_attention_line,
  output wire out_valid,
  input wire out_ready,
  output wire [7:0] out_data,
  output wire out_last,
  output wire out_empty,
  output wire [1:0] out_path,
  output wire [7:0] out_hdr,
  output wire [7:0] out_ctrl_hi,
  output wire [7:0] out_count,
  input wire dev_wr_en,
  input wire [AW-1:0] dev_wr_addr,
  input wire [7:0] dev_wr_data,
  input wire dev_msg_valid,
  output wire dev_msg_ready,
  input wire dev_msg_is_resp,
  input wire [7:0] dev_msg_hdr,
  input wire [7:0] dev_msg_ctrl_hi,
  input wire [7:0] dev_msg_count,
  input wire [GPIO_W-1:0] gpio_pins,
  input wire [GPIO_W-1:0] gpio_event_en
);
  localparam ST_IDLE = 1'b0;
  localparam ST_SEND = 1'b1;

  // Host-facing register state
  reg [AW-1:0] rd_ptr_q;
  reg [AW-1:0] wr_ptr_q;
  reg [7:0] host_hdr_q;
  reg [7:0] host_ctrl_q;
  reg [7:0] host_count_q;
  reg [7:0] dev_hdr_q;
  reg [7:0] dev_ctrl_q;
  reg [7:0] dev_count_q;
  reg busy_q;
  reg pending_q;
  reg attn_en_q;
  reg attn_q;
  // Bus slave state
  reg aw_got_q;
  reg w_got_q;
  reg [3:0] aw_idx_q;
  reg aw_bad_q;
  reg [7:0] wdata_q;
  reg wstrb0_q;
  reg bvalid_q;
  reg [1:0] bresp_q;
  reg rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0] rresp_q;
  // Transfer engine and message sources
  reg state_q;
  reg [7:0] idx_q;
  reg [1:0] path_q;
  reg req_seen_q;
  reg gpio_want_q;
  reg [GPIO_W-1:0] gpio_s1_q;
  reg [GPIO_W-1:0] gpio_s2_q;
  reg [GPIO_W-1:0] gpio_old_q;

  wire [7:0] inbox_rd;
  wire [7:0] outbox_rd;

  // ====================================================================
  // Address decode
  wire [3:0] ar_idx = s_axi_araddr[5:2];
  wire ar_bad = (s_axi_araddr[7:6] != 2'h0) || (ar_idx > `IDX_LAST);
  wire [3:0] aw_idx = s_axi_awaddr[5:2];
  wire aw_bad = (s_axi_awaddr[7:6] != 2'h0) || (aw_idx > `IDX_LAST);

  // ====================================================================
  // AXI4-Lite handshakes; address and data may arrive in either order
  assign s_axi_awready = ~aw_got_q & ~bvalid_q;
  assign s_axi_wready = ~w_got_q & ~bvalid_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  wire aw_hs = s_axi_awvalid & s_axi_awready;
  wire w_hs = s_axi_wvalid & s_axi_wready;
  wire ar_hs = s_axi_arvalid & s_axi_arready;
  wire do_wr = aw_got_q & w_got_q & ~bvalid_q;
  // Only the low byte lane carries register data
  wire wr_ok = do_wr & ~aw_bad_q & wstrb0_q;
  wire rd_ok = ar_hs & ~ar_bad;

  // Host-to-device data, header, control-byte and count writes are locked out while a message is moving; pointer writes are not
  wire wr_open = wr_ok & ~busy_q;
  wire wr_data_port = wr_open & (aw_idx_q == `IDX_DATA);
  wire wr_rd_ptr = wr_ok & (aw_idx_q == `IDX_RD_PTR);
  wire wr_wr_ptr = wr_ok & (aw_idx_q == `IDX_WR_PTR);
  wire rd_data_port = rd_ok & (ar_idx == `IDX_DATA);

  // Either a write or a read of the header commits the message
  wire hdr_wr = wr_open & (aw_idx_q == `IDX_HOST_HDR);
  wire hdr_rd = rd_ok & (ar_idx == `IDX_HOST_HDR) & ~busy_q;
  wire commit = hdr_wr | hdr_rd;
  wire [7:0] commit_hdr = hdr_wr ? wdata_q : host_hdr_q;

  // Writing the ack byte with its bit low releases the outbox
  wire ack_clr = wr_ok & (aw_idx_q == `IDX_DEV_ACK) &
                 ~wdata_q[`ACK_BIT] & pending_q;

  // ====================================================================
  // Bus slave channel registers
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_idx_q <= 4'h0;
      aw_bad_q <= 1'b0;
      wdata_q <= `RST_BYTE;
      wstrb0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
    end else begin
      if (aw_hs) begin
        aw_got_q <= 1'b1;
        aw_idx_q <= aw_idx;
        aw_bad_q <= aw_bad;
      end
      if (w_hs) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (do_wr) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= aw_bad_q ? `RESP_SLVERR : `RESP_OKAY;
      end else if (bvalid_q & s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ====================================================================
  // Read data mux, captured when the address is taken
  reg [7:0] rd_byte;
  always @* begin
    rd_byte = 8'h00;
    case (ar_idx)
      `IDX_RD_PTR: rd_byte = rd_ptr_q;
      `IDX_WR_PTR: rd_byte = wr_ptr_q;
      `IDX_DATA: rd_byte = outbox_rd;
      `IDX_HOST_HDR: rd_byte = host_hdr_q;
      `IDX_HOST_CTRL_HI: rd_byte = host_ctrl_q;
      `IDX_HOST_COUNT: rd_byte = host_count_q;
      `IDX_DEV_HDR: rd_byte = dev_hdr_q;
      `IDX_DEV_CTRL_HI: rd_byte = dev_ctrl_q;
      `IDX_DEV_COUNT: rd_byte = dev_count_q;
      `IDX_STATUS: rd_byte = {6'h00, pending_q, busy_q};
      `IDX_CONTROL: rd_byte = {7'h00, attn_en_q};
      `IDX_DEV_ACK: rd_byte = {7'h00, pending_q};
      default: rd_byte = 8'h00;
    endcase
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `RESP_OKAY;
    end else if (ar_hs) begin
      rvalid_q <= 1'b1;
      rdata_q <= ar_bad ? 32'h00000000 : {24'h000000, rd_byte};
      rresp_q <= ar_bad ? `RESP_SLVERR : `RESP_OKAY;
    end else if (rvalid_q & s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ====================================================================
  // Pointers; a pointer write beats an auto-increment in the same cycle
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_ptr_q <= {AW{1'b0}};
      wr_ptr_q <= {AW{1'b0}};
    end else begin
      if (wr_rd_ptr) begin
        rd_ptr_q <= wdata_q[AW-1:0];
      end else if (rd_data_port) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (wr_wr_ptr) begin
        wr_ptr_q <= wdata_q[AW-1:0];
      end else if (wr_data_port) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
    end
  end

  // ====================================================================
  // Host message header and control bytes
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      host_hdr_q <= `RST_BYTE;
      host_ctrl_q <= `RST_BYTE;
      host_count_q <= `RST_BYTE;
      attn_en_q <= `RST_ATTN_EN;
    end else begin
      if (hdr_wr) begin
        host_hdr_q <= wdata_q;
      end
      if (wr_open & (aw_idx_q == `IDX_HOST_CTRL_HI)) begin
        host_ctrl_q <= wdata_q;
      end
      if (wr_open & (aw_idx_q == `IDX_HOST_COUNT)) begin
        host_count_q <= wdata_q;
      end
      if (wr_ok & (aw_idx_q == `IDX_CONTROL)) begin
        attn_en_q <= wdata_q[`CTL_ATTN_EN_BIT];
      end
    end
  end

  // ====================================================================
  // Transfer engine: drains the inbox to the selected datapath
  wire send_last = (host_count_q == 8'h00) ||
                   (idx_q == host_count_q - 8'h01);
  wire send_done = (state_q == ST_SEND) & out_ready & send_last;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      idx_q <= 8'h00;
      path_q <= 2'h0;
      busy_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (commit) begin
            state_q <= ST_SEND;
            idx_q <= 8'h00;
            path_q <= commit_hdr[`HDR_PATH_HI:`HDR_PATH_LO];
            busy_q <= 1'b1;
          end
        end
        ST_SEND: begin
          if (out_ready) begin
            if (send_last) begin
              state_q <= ST_IDLE;
              busy_q <= 1'b0;
            end else begin
              idx_q <= idx_q + 8'h01;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  assign out_valid = (state_q == ST_SEND);
  assign out_data = inbox_rd;
  assign out_last = send_last;
  assign out_empty = (host_count_q == 8'h00);
  assign out_path = path_q;
  assign out_hdr = host_hdr_q;
  assign out_ctrl_hi = host_ctrl_q;
  assign out_count = host_count_q;

  // ====================================================================
  // GPIO pins come from outside, so two flops before any use
  wire [GPIO_W-1:0] gpio_chg = (gpio_s2_q ^ gpio_old_q) & gpio_event_en;
  // Widened first, so any pin count yields one report byte
  wire [GPIO_W+7:0] gpio_level = {8'h00, gpio_s2_q};
  wire gpio_launch = gpio_want_q & ~pending_q;
  wire gpio_query = commit & (commit_hdr == GPIO_QUERY_HDR);

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gpio_s1_q <= {GPIO_W{1'b0}};
      gpio_s2_q <= {GPIO_W{1'b0}};
      gpio_old_q <= {GPIO_W{1'b0}};
      gpio_want_q <= 1'b0;
    end else begin
      gpio_s1_q <= gpio_pins;
      gpio_s2_q <= gpio_s1_q;
      gpio_old_q <= gpio_s2_q;
      // A new event in the launch cycle keeps the request alive
      gpio_want_q <= (gpio_want_q & ~gpio_launch) |
                     (|gpio_chg) | gpio_query;
    end
  end

  // ====================================================================
  // Outgoing messages; GPIO reports take precedence over others
  assign dev_msg_ready = ~pending_q & ~gpio_want_q &
                         (~dev_msg_is_resp | req_seen_q);
  wire dev_take = dev_msg_valid & dev_msg_ready;
  wire dev_mem_wr = dev_wr_en & ~pending_q; // outbox frozen while shown

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dev_hdr_q <= `RST_BYTE;
      dev_ctrl_q <= `RST_BYTE;
      dev_count_q <= `RST_BYTE;
      pending_q <= 1'b0;
      req_seen_q <= 1'b0;
      attn_q <= 1'b0;
    end else begin
      if (gpio_launch) begin
        dev_hdr_q <= GPIO_REPORT_HDR;
        dev_ctrl_q <= gpio_level[7:0];
        dev_count_q <= 8'h00;
      end else if (dev_take) begin
        dev_hdr_q <= dev_msg_hdr;
        dev_ctrl_q <= dev_msg_ctrl_hi;
        dev_count_q <= dev_msg_count;
      end
      // Set only when clear, so set and ack never meet in one cycle
      if (gpio_launch | dev_take) begin
        pending_q <= 1'b1;
      end else if (ack_clr) begin
        pending_q <= 1'b0;
      end
      if (commit) begin
        req_seen_q <= 1'b1;
      end else if (dev_take & dev_msg_is_resp) begin
        req_seen_q <= 1'b0;
      end
      attn_q <= pending_q & attn_en_q & ~ack_clr;
    end
  end

  assign host_attention_line = attn_q;

  // ====================================================================
  // Mailbox storage, one array per direction
  mbx_ram #(.AW(AW)) u_inbox (
    .sys_clk(sys_clk),
    .wr_en(wr_data_port),
    .wr_addr(wr_ptr_q),
    .wr_data(wdata_q),
    .rd_addr(idx_q[AW-1:0]),
    .rd_data(inbox_rd)
  );

  mbx_ram #(.AW(AW)) u_outbox (
    .sys_clk(sys_clk),
    .wr_en(dev_mem_wr),
    .wr_addr(dev_wr_addr),
    .wr_data(dev_wr_data),
    .rd_addr(rd_ptr_q),
    .rd_data(outbox_rd)
  );
endmodule

// *** dv/mbx_monitor.sv ***
// Protocol and behaviour checker bound to the mailbox top
`timescale 1ns/100ps
module mbx_monitor (
  input wire sys_clk,
  input wire rst_n,
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire host_attention_line,
  input wire out_valid,
  input wire out_ready,
  input wire [7:0] out_data,
  input wire out_last,
  input wire out_empty,
  input wire dev_msg_valid,
  input wire dev_msg_ready
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // ==========================================
  // Register bus answers
  a_bresp_legal: assert property (s_axi_bvalid |->
    s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2) else $error("bad bresp");
  a_w_blocked: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken early");
  a_b_drops: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid) else $error("bvalid stuck");
  a_ar_blocked: assert property (s_axi_rvalid |->
    !s_axi_arready) else $error("read taken early");
  a_r_drops: assert property (s_axi_rvalid && s_axi_rready
    |=> !s_axi_rvalid) else $error("rvalid stuck");
  a_rdata_byte: assert property (s_axi_rvalid |->
    s_axi_rdata[31:8] == 24'h000000) else $error("upper rdata set");
  // ==========================================
  // Message flags and the internal stream
  a_attn_pend: assert property (host_attention_line |->
    !dev_msg_ready) else $error("attention without message");
  a_take_pend: assert property (dev_msg_valid && dev_msg_ready
    |=> !dev_msg_ready [*3]) else $error("message not held");
  a_out_hold: assert property (out_valid && !out_ready |=>
    out_valid && $stable(out_data) && $stable(out_last))
    else $error("stream beat changed");
  a_empty_last: assert property (out_valid && out_empty |->
    out_last) else $error("empty beat not last");
endmodule

bind host_message_mailbox mbx_monitor mon_i (
  .sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .host_attention_line(host_attention_line), .out_valid(out_valid),
  .out_ready(out_ready), .out_data(out_data), .out_last(out_last),
  .out_empty(out_empty), .dev_msg_valid(dev_msg_valid),
  .dev_msg_ready(dev_msg_ready)
);

// *** dv/mbx_sink.sv ***
// Destination buffer model that drains the mailbox stream
`timescale 1ns/100ps
module mbx_sink (
  input wire sys_clk,
  input wire rst_n,
  input wire stall,
  input wire out_valid,
  output reg out_ready,
  input wire [7:0] out_data,
  input wire out_last,
  input wire out_empty,
  input wire [1:0] out_path
);
  integer seed = 95;
  integer beat = 0;
  integer msgs = 0;
  integer empties = 0;
  reg [31:0] rnd;
  reg [7:0] got [0:15];
  reg [1:0] path_q;
  // Random stalls; a real buffer is not always ready
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_ready <= 1'h0;
      beat <= 0;
    end else begin
      rnd = $random(seed);
      out_ready <= !stall && rnd[0];
      if (out_valid && out_ready) begin
        if (!out_empty) got[beat] <= out_data;
        path_q <= out_path;
        beat <= out_last ? 0 : beat + 1;
        if (out_last) msgs <= msgs + 1;
        if (out_empty) empties <= empties + 1;
      end
    end
  end
endmodule

// *** dv/testbench.sv ***
// Self-checking bench for the host message mailbox
`timescale 1ns/100ps
`include "mbx_consts.vh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module testbench;
  reg sys_clk = 1'h0;
  reg rst_n = 1'h0;
  integer seed = 95;
  integer err_total = 0;
  integer checks_done = 0;
  integer m, n, k;
  reg [31:0] rnd;
  reg [7:0] h, aa = 8'h00, ra = 8'h00, wd = 8'h00;
  reg av = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0;
  reg dwe = 1'h0, dmv = 1'h0, dmr = 1'h0, stall = 1'h0;
  reg [7:0] dwa = 8'h00, dwd = 8'h00, dh = 8'h00, dc = 8'h00, dn = 8'h00;
  reg [7:0] gp = 8'h00, ge = 8'h00, rdv;
  reg [7:0] exp_b [0:15];
  reg [1:0] resp;
  wire awr, wrdy, bv, arr, rv, attn, ov, ordy, olast, oemp, dmrdy;
  wire [1:0] bresp, rresp, opath;
  wire [31:0] rdata;
  wire [7:0] odata;
  // ==========================================
  // Clock, design and destination model
  always #25 sys_clk = ~sys_clk;
  host_message_mailbox host_message_mailbox_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(aa),
    .s_axi_awvalid(av), .s_axi_awready(awr), .s_axi_wdata({24'h000000, wd}),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ra), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .host_attention_line(attn), .out_valid(ov),
    .out_ready(ordy), .out_data(odata), .out_last(olast), .out_empty(oemp),
    .out_path(opath), .out_hdr(), .out_ctrl_hi(), .out_count(),
    .dev_wr_en(dwe), .dev_wr_addr(dwa), .dev_wr_data(dwd),
    .dev_msg_valid(dmv), .dev_msg_ready(dmrdy), .dev_msg_is_resp(dmr),
    .dev_msg_hdr(dh), .dev_msg_ctrl_hi(dc), .dev_msg_count(dn),
    .gpio_pins(gp), .gpio_event_en(ge));
  mbx_sink sink_i (.sys_clk(sys_clk), .rst_n(rst_n), .stall(stall),
    .out_valid(ov), .out_ready(ordy), .out_data(odata), .out_last(olast),
    .out_empty(oemp), .out_path(opath));
  // ==========================================
  // Bus tasks; unmapped indices must be refused
  function [1:0] exp_resp(input [3:0] i);
    exp_resp = i > `IDX_LAST ? `RESP_SLVERR : `RESP_OKAY;
  endfunction
  task wr(input [3:0] i, input [7:0] d);
    begin
      @(posedge sys_clk);
      aa <= {2'h0, i, 2'h0};
      wd <= d;
      av <= 1'h1;
      wv <= 1'h1;
      br <= 1'h1;
      @(posedge sys_clk);
      while (!bv) begin
        if (av && awr) av <= 1'h0;
        if (wv && wrdy) wv <= 1'h0;
        @(posedge sys_clk);
      end
      br <= 1'h0;
      `CHK(bresp, exp_resp(i))
    end
  endtask
  // Plain read; data and response kept for the caller
  task rd(input [3:0] i);
    begin
      @(posedge sys_clk);
      ra <= {2'h0, i, 2'h0};
      arv <= 1'h1;
      rr <= 1'h1;
      @(posedge sys_clk);
      while (!rv) begin
        if (arr) arv <= 1'h0;
        @(posedge sys_clk);
      end
      rr <= 1'h0;
      rdv = rdata[7:0];
      resp = rresp;
    end
  endtask
  task rchk(input [3:0] i, input [7:0] e);
    begin
      rd(i);
      `CHK({resp, rdv}, {exp_resp(i), e})
    end
  endtask
  // Status polling looks only at the awaited bit; the rest may vary
  task poll(input integer b, input v);
    begin
      rd(`IDX_STATUS);
      while (rdv[b] !== v) rd(`IDX_STATUS);
    end
  endtask
  task host_msg(input [7:0] hd, input [7:0] cnt, input part);
    integer j;
    begin
      poll(`STAT_BUSY_BIT, 1'h0);
      wr(`IDX_HOST_CTRL_HI, 8'h3C);
      wr(`IDX_HOST_COUNT, cnt);
      wr(`IDX_WR_PTR, {7'h00, part});
      for (j = part; j < (part ? 2 : cnt); j = j + 1)
        wr(`IDX_DATA, exp_b[j]);
      wr(`IDX_HOST_HDR, hd);
    end
  endtask
  task dev_msg(input [7:0] hd, input [7:0] cnt);
    integer j;
    begin
      for (j = 0; j < cnt; j = j + 1) begin
        @(posedge sys_clk);
        dwe <= 1'h1;
        dwa <= j[7:0];
        dwd <= exp_b[j];
      end
      @(posedge sys_clk);
      dwe <= 1'h0;
      dmv <= 1'h1;
      dh <= hd;
      dc <= ~hd;
      dn <= cnt;
      @(posedge sys_clk);
      while (!dmrdy) @(posedge sys_clk);
      dmv <= 1'h0;
    end
  endtask
  task end_sim;
    begin
      $display("errors %0d checks %0d", err_total, checks_done);
      if (err_total == 0 && checks_done > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // Hang guard, far beyond the few hundred cycles needed
  initial begin
    #2000000;
    err_total++;
    end_sim;
  end
  // ==========================================
  // Scenarios
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'h1;
    dmr <= 1'h1;
    ge <= 8'h01;
    repeat (2) @(posedge sys_clk);
    `CHK(dmrdy, 1'h0)
    dmr <= 1'h0;
    rchk(`IDX_STATUS, 8'h00);
    rchk(`IDX_CONTROL, 8'h00);
    wr(4'hC, 8'h55);
    rchk(4'hD, 8'h00);
    // Full message held in flight, partial rewrite, then empty
    for (m = 0; m < 3; m = m + 1) begin
      rnd = $random(seed);
      h = {rnd[1:0], 6'h05};
      if (m == 0) n = 2 + {$random(seed)} % 6;
      if (m == 2) n = 0;
      for (k = 0; k < n; k = k + 1)
        if (m == 0 || k == 1) exp_b[k] = $random(seed);
      stall <= (m == 0);
      host_msg(h, n, m == 1);
      if (m == 0) begin
        rchk(`IDX_STATUS, 8'h01);
        stall <= 1'h0;
      end
      wait (sink_i.msgs == m + 1);
      rchk(`IDX_STATUS, 8'h00);
      `CHK(sink_i.path_q, h[7:6])
      for (k = 0; k < n; k = k + 1)
        `CHK(sink_i.got[k], exp_b[k])
    end
    `CHK(sink_i.empties, 1)
    // A header read commits as well, here an empty message again
    rchk(`IDX_HOST_HDR, h);
    wait (sink_i.msgs == 4);
    `CHK(sink_i.empties, 2)
    // Masked message, then attention, read out and release
    for (k = 0; k < 4; k = k + 1) exp_b[k] = $random(seed);
    dev_msg(8'h4A, 4);
    rchk(`IDX_STATUS, 8'h02);
    `CHK(attn, 1'h0)
    wr(`IDX_CONTROL, 8'h01);
    repeat (2) @(posedge sys_clk);
    `CHK(attn, 1'h1)
    rchk(`IDX_STATUS, 8'h02);
    rchk(`IDX_DEV_HDR, 8'h4A);
    rchk(`IDX_DEV_CTRL_HI, 8'hB5);
    rchk(`IDX_DEV_COUNT, 8'h04);
    wr(`IDX_RD_PTR, 8'h00);
    for (k = 0; k < 4; k = k + 1)
      rchk(`IDX_DATA, exp_b[k]);
    wr(`IDX_DEV_ACK, 8'h00);
    rchk(`IDX_STATUS, 8'h00);
    `CHK(attn, 1'h0)
    // A response is taken after a host request, which it then uses up
    dmr <= 1'h1;
    dev_msg(8'h4B, 2);
    wr(`IDX_DEV_ACK, 8'h00);
    rchk(`IDX_STATUS, 8'h00);
    `CHK(dmrdy, 1'h0)
    dmr <= 1'h0;
    // Level reports: host query, then an enabled pin change
    host_msg(8'hF0, 0, 0);
    poll(`STAT_PEND_BIT, 1'h1);
    rchk(`IDX_DEV_HDR, 8'hF1);
    rchk(`IDX_DEV_CTRL_HI, gp);
    wr(`IDX_DEV_ACK, 8'h00);
    rnd = $random(seed);
    gp <= {rnd[7:1], 1'h1};
    poll(`STAT_PEND_BIT, 1'h1);
    rchk(`IDX_DEV_CTRL_HI, gp);
    rchk(`IDX_DEV_COUNT, 8'h00);
    wr(`IDX_DEV_ACK, 8'h00);
    end_sim;
  end
endmodule
